// file: hw/msp_serial_port.sv
// serial port with timer 1 baud source, four modes and a byte register port
// Operation
// - mode bits pick shift register, 8-bit variable, 9-bit fixed, 9-bit variable
// - variable modes take bit rate from timer 1 overflows
// - baud doubler selects factor two, otherwise one
// - tick is main clock divided by 2^n, n the clock divide field
// - 9-bit modes with filter drop frames whose ninth bit is 0
// - 8-bit mode with filter drops frames without valid stop bit
// - receive enable allows reception, clear blocks it
// - 9-bit modes send the written ninth transmit bit
// - ninth receive field gets ninth bit, or stop bit in 8-bit mode
// - transmit done set after eighth shift bit or at stop start
// - receive done set after eighth shift bit or mid stop bit
// - transmit and receive paths run independently and together, except in shift mode: receive waits for transmit idle, a data write while receiving is lost
// - data register read returns the receive holding byte
// - data register write loads and starts the transmitter
// - serial control resets to zero, every bit read-write
// - data register holds no reset value
// - timer 1 low byte counts and reloads from high byte
// - timer 1 counts only while its run bit is set
`timescale 1ns/100ps
module msp_serial_port #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [msp_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [msp_pkg::DATA_W-1:0] RDATA,
    // serial line
    input wire logic RXD_IN,
    output logic RXD_OUT,
    output logic RXD_OE,
    output logic TXD
);
    import msp_pkg::*;

    generate
        if (ADDR_W < 8) begin : g_chk
            $error("ADDR_W must be at least 8");
        end
    endgenerate

    logic [7:0] serial_control_reg, tl1_reg, th1_reg, rdata_reg, hold_reg, rx_sh_reg;
    logic [2:0] cdiv_reg;
    logic baud_doubler_reg, t1_run_reg, ovf_half_reg, rx_s1_reg, rx_s2_reg, rx9_reg;
    logic txd_reg, rxo_reg, rxoe_reg, tx_ph_reg, rx_ph_reg;
    logic [10:0] tx_sh_reg;
    logic [3:0] tx_sc_reg, tx_idx_reg, rx_sc_reg, rx_idx_reg, mc_cnt;
    msp_state_t tx_st_reg, rx_st_reg;
    msp_mode_t mode;
    logic tick, mc_tick, mc_half, m2_pulse, t1_ovf, samp, var_mode, nine;
    logic a_serial_control, a_serial_data_port, a_tl1, a_th1, a_tctl, a_pwr, a_cdiv;
    logic [7:0] tick_load;
    logic [3:0] tx_last, rx_last;
    logic tx_stop_go, tx0_end, ti_set, rx_accept, rx0_done, ri_set, filt_ok;

    // address decode
    assign a_serial_control = (ADDR == ADDR_W'(ADR_SERIAL_CONTROL));
    assign a_serial_data_port = (ADDR == ADDR_W'(ADR_SERIAL_DATA_PORT));
    assign a_tl1 = (ADDR == ADDR_W'(ADR_TL1));
    assign a_th1 = (ADDR == ADDR_W'(ADR_TH1));
    assign a_tctl = (ADDR == ADDR_W'(ADR_TCTL));
    assign a_pwr = (ADDR == ADDR_W'(ADR_PWR));
    assign a_cdiv = (ADDR == ADDR_W'(ADR_CDIV));

    // mode decode
    assign mode = msp_mode_t'(serial_control_reg[7:6]);
    assign var_mode = serial_control_reg[6];
    assign nine = serial_control_reg[7];
    assign tx_last = nine ? LAST_BIT9 : LAST_BIT8;
    assign rx_last = nine ? LAST_BIT9 : LAST_BIT8;

    // tick = main clock over 2^n, n from the clock divide field
    assign tick_load = 8'((9'h001 << cdiv_reg) - 9'h001);
    msp_div #(.W(8)) u_tick (
        .clk(CLK),
        .arst_n(ARST_N),
        .en(1'b1),
        .load(tick_load),
        .pulse(tick),
        .cnt()
    );

    // machine cycle = tick over 12, also the shift register bit time
    msp_div #(.W(4)) u_mc (
        .clk(CLK),
        .arst_n(ARST_N),
        .en(tick),
        .load(MC_LOAD),
        .pulse(mc_tick),
        .cnt(mc_cnt)
    );
    assign mc_half = tick && (mc_cnt == MC_HALF);

    // fixed-rate 9-bit mode: 16 samples per bit at tick over 64 or 32
    msp_div #(.W(2)) u_m2 (
        .clk(CLK),
        .arst_n(ARST_N),
        .en(tick),
        .load(baud_doubler_reg ? M2_LOAD_K2 : M2_LOAD_K1),
        .pulse(m2_pulse),
        .cnt()
    );

    // timer 1 overflow; each one is a sample at K=2, one of two at K=1
    assign t1_ovf = mc_tick && t1_run_reg && (tl1_reg == T1_TOP);
    assign samp = var_mode ? (t1_ovf && (baud_doubler_reg || ovf_half_reg)) : m2_pulse;

    // timer 1 in auto-reload: low byte counts machine cycles, reloads from high byte
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tl1_reg <= T1_RST;
            th1_reg <= T1_RST;
            ovf_half_reg <= 1'b0;
        end else begin
            if (WR && a_th1) begin
                th1_reg <= WDATA;
            end
            if (WR && a_tl1) begin
                tl1_reg <= WDATA;
            end else if (mc_tick && t1_run_reg) begin
                tl1_reg <= (tl1_reg == T1_TOP) ? th1_reg : tl1_reg + 8'h01;
            end
            if (t1_ovf) begin
                ovf_half_reg <= !ovf_half_reg;
            end
        end
    end

    // control registers: timer run, baud doubler, clock divide
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            t1_run_reg <= 1'b0;
            baud_doubler_reg <= 1'b0;
            cdiv_reg <= CDIV_RST;
        end else if (WR) begin
            if (a_tctl) begin
                t1_run_reg <= WDATA[TCTL_RUN];
            end
            if (a_pwr) begin
                baud_doubler_reg <= WDATA[PWR_DBL];
            end
            if (a_cdiv) begin
                cdiv_reg <= WDATA[CDIV_W-1:0];
            end
        end
    end

    // line input synchroniser
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= RXD_IN;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    // transmit completion points
    assign tx_stop_go = (tx_st_reg == ST_ASYNC) && samp && (tx_sc_reg == '0) && (tx_idx_reg == tx_last);
    assign tx0_end = (tx_st_reg == ST_SHIFT) && mc_half && tx_ph_reg && (tx_idx_reg == SHIFT_LAST);
    assign ti_set = tx_stop_go || tx0_end;

    // transmitter and line drivers; shift clock also serves mode 0 reception
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_st_reg <= ST_IDLE;
            tx_sh_reg <= '1;
            tx_sc_reg <= '0;
            tx_idx_reg <= '0;
            tx_ph_reg <= 1'b0;
            txd_reg <= 1'b1;
            rxo_reg <= 1'b1;
            rxoe_reg <= 1'b0;
        end else begin
            unique case (tx_st_reg)
                ST_IDLE: begin
                    if (WR && a_serial_data_port && mode != MSP_SHIFT) begin
                        tx_st_reg <= ST_ASYNC;
                        tx_sh_reg <= {1'b1, nine ? serial_control_reg[SC_TB8] : 1'b1, WDATA, 1'b0};
                        tx_sc_reg <= '0;
                        tx_idx_reg <= '0;
                    end else if (WR && a_serial_data_port && rx_st_reg == ST_IDLE) begin
                        tx_st_reg <= ST_SHIFT;
                        tx_sh_reg <= {3'b111, WDATA};
                        tx_idx_reg <= '0;
                        tx_ph_reg <= 1'b0;
                    end
                end
                ST_ASYNC: begin
                    if (samp) begin
                        tx_sc_reg <= tx_sc_reg + 4'h1;
                        if (tx_sc_reg == '0) begin
                            txd_reg <= tx_sh_reg[0];
                            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
                        end
                        if (tx_sc_reg == SMP_LAST) begin
                            tx_idx_reg <= tx_idx_reg + 4'h1;
                            if (tx_idx_reg == tx_last) begin
                                tx_st_reg <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_SHIFT: begin
                    if (mc_tick) begin
                        rxo_reg <= tx_sh_reg[0];
                        rxoe_reg <= 1'b1;
                        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
                        tx_ph_reg <= 1'b1;
                    end else if (mc_half && tx_ph_reg) begin
                        tx_ph_reg <= 1'b0;
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                        if (tx_idx_reg == SHIFT_LAST) begin
                            tx_st_reg <= ST_IDLE;
                            rxoe_reg <= 1'b0;
                        end
                    end
                end
                default: begin
                    tx_st_reg <= ST_IDLE;
                end
            endcase
            // shift clock: low from the machine cycle start, high at its middle
            if (tx_st_reg == ST_SHIFT || rx_st_reg == ST_SHIFT) begin
                if (mc_tick) begin
                    txd_reg <= 1'b0;
                end else if (mc_half) begin
                    txd_reg <= 1'b1;
                end
            end
        end
    end

    // receive acceptance with multiprocessor filter
    assign filt_ok = !serial_control_reg[SC_FILT] || (nine ? rx9_reg : rx_s2_reg);
    assign rx_accept = (rx_st_reg == ST_ASYNC) && samp && (rx_sc_reg == SMP_MID) && (rx_idx_reg == rx_last)
        && !serial_control_reg[SC_RI] && filt_ok;
    assign rx0_done = (rx_st_reg == ST_SHIFT) && mc_half && rx_ph_reg && (rx_idx_reg == SHIFT_LAST);
    assign ri_set = rx_accept || rx0_done;

    // receiver state, independent of the transmitter except that shift mode waits for it to idle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_st_reg <= ST_IDLE;
            rx_sc_reg <= '0;
            rx_idx_reg <= '0;
            rx_ph_reg <= 1'b0;
            rx9_reg <= 1'b0;
        end else if (!serial_control_reg[SC_REN]) begin
            rx_st_reg <= ST_IDLE;
        end else begin
            unique case (rx_st_reg)
                ST_IDLE: begin
                    if (mode != MSP_SHIFT && samp && !rx_s2_reg) begin
                        rx_st_reg <= ST_ASYNC;
                        rx_sc_reg <= 4'h1;
                        rx_idx_reg <= '0;
                    end else if (mode == MSP_SHIFT && mc_tick && !serial_control_reg[SC_RI] && tx_st_reg == ST_IDLE) begin
                        rx_st_reg <= ST_SHIFT;
                        rx_idx_reg <= '0;
                        rx_ph_reg <= 1'b0;
                    end
                end
                ST_ASYNC: begin
                    if (samp) begin
                        rx_sc_reg <= rx_sc_reg + 4'h1;
                        if (rx_sc_reg == SMP_MID) begin
                            if (rx_idx_reg == '0 && rx_s2_reg) begin
                                rx_st_reg <= ST_IDLE; // false start
                            end else if (rx_idx_reg == rx_last) begin
                                rx_st_reg <= ST_IDLE;
                            end else if (rx_idx_reg == LAST_BIT8) begin
                                rx9_reg <= rx_s2_reg;
                            end
                        end
                        if (rx_sc_reg == SMP_LAST) begin
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (mc_tick) begin
                        rx_ph_reg <= 1'b1;
                    end else if (mc_half && rx_ph_reg) begin
                        rx_ph_reg <= 1'b0;
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == SHIFT_LAST) begin
                            rx_st_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    rx_st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // receive shifter and holding byte, no reset on data
    always_ff @(posedge CLK) begin
        if ((rx_st_reg == ST_ASYNC && samp && rx_sc_reg == SMP_MID && rx_idx_reg != '0
            && rx_idx_reg < LAST_BIT8) || (rx_st_reg == ST_SHIFT && mc_half && rx_ph_reg)) begin
            rx_sh_reg <= {rx_s2_reg, rx_sh_reg[7:1]};
        end
        if (rx_accept) begin
            hold_reg <= rx_sh_reg;
        end else if (rx0_done) begin
            hold_reg <= {rx_s2_reg, rx_sh_reg[7:1]};
        end
    end

    // serial control: software bits, sticky done flags where set beats clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            serial_control_reg <= SERIAL_CONTROL_RST;
        end else begin
            if (WR && a_serial_control) begin
                serial_control_reg[7:3] <= WDATA[7:3];
            end
            if (rx_accept) begin
                serial_control_reg[SC_RB8] <= nine ? rx9_reg : rx_s2_reg;
            end else if (WR && a_serial_control) begin
                serial_control_reg[SC_RB8] <= WDATA[SC_RB8];
            end
            serial_control_reg[SC_TI] <= ti_set || (WR && a_serial_control ? WDATA[SC_TI] : serial_control_reg[SC_TI]);
            serial_control_reg[SC_RI] <= ri_set || (WR && a_serial_control ? WDATA[SC_RI] : serial_control_reg[SC_RI]);
        end
    end

    // read data, valid the cycle after the read strobe
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_reg <= '0;
        end else if (RD) begin
            rdata_reg <= a_serial_control ? serial_control_reg :
                a_serial_data_port ? hold_reg :
                a_tl1 ? tl1_reg :
                a_th1 ? th1_reg :
                a_tctl ? {1'b0, t1_run_reg, 6'h00} :
                a_pwr ? {baud_doubler_reg, 7'h00} :
                a_cdiv ? {5'h00, cdiv_reg} : 8'h00;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign RDATA = rdata_reg;
    assign TXD = txd_reg;
    assign RXD_OUT = rxo_reg;
    assign RXD_OE = rxoe_reg;

    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    property p_t1_hold;
        !t1_run_reg && !(WR && a_tl1) |=> $stable(tl1_reg);
    endproperty
    a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved while stopped");

    property p_t1_reload;
        t1_ovf && !(WR && a_tl1) |=> tl1_reg == $past(th1_reg);
    endproperty
    a_t1_reload: assert property (p_t1_reload) else $error("timer 1 did not reload");

    property p_k_one;
        var_mode && samp && !baud_doubler_reg |-> t1_ovf && ovf_half_reg;
    endproperty
    a_k_one: assert property (p_k_one) else $error("sample without second overflow");

    property p_tick_rate;
        cdiv_reg == 3'h1 && tick && !(WR && a_cdiv) |=> !tick ##1 tick;
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("tick not every second clock");

    property p_ren_block;
        !serial_control_reg[SC_REN] && rx_st_reg == ST_IDLE |=> rx_st_reg == ST_IDLE;
    endproperty
    a_ren_block: assert property (p_ren_block) else $error("reception while disabled");

    property p_tx_start;
        WR && a_serial_data_port && tx_st_reg == ST_IDLE && mode != MSP_SHIFT |=> tx_st_reg == ST_ASYNC;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("data write did not start sending");

    property p_ti_stop;
        tx_stop_go |=> TXD && serial_control_reg[SC_TI];
    endproperty
    a_ti_stop: assert property (p_ti_stop) else $error("stop bit start without done flag");

    property p_filter9;
        nine && serial_control_reg[SC_FILT] && $rose(serial_control_reg[SC_RI]) && !$past(WR && a_serial_control) |-> serial_control_reg[SC_RB8];
    endproperty
    a_filter9: assert property (p_filter9) else $error("filtered frame raised done");

    property p_serial_control_wr;
        WR && a_serial_control |=> serial_control_reg[7:3] == $past(WDATA[7:3]);
    endproperty
    a_serial_control_wr: assert property (p_serial_control_wr) else $error("control write lost");

    c_tx_async: cover property (tx_stop_go);
    c_rx_async: cover property (rx_accept);
    c_rx_shift: cover property (rx0_done);
    c_tx_shift: cover property (tx0_end);
endmodule

// file: hw/msp_pkg.sv
// serial port constants: register map, field positions, reset values, rate divisors, states
package msp_pkg;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] ADR_PWR = 8'h87;
    localparam logic [7:0] ADR_TCTL = 8'h88;
    localparam logic [7:0] ADR_TL1 = 8'h8B;
    localparam logic [7:0] ADR_TH1 = 8'h8D;
    localparam logic [7:0] ADR_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] ADR_SERIAL_DATA_PORT = 8'h99;
    localparam logic [7:0] ADR_CDIV = 8'h9D;
    // serial_control fields
    localparam int SC_FILT = 5;
    localparam int SC_REN = 4;
    localparam int SC_TB8 = 3;
    localparam int SC_RB8 = 2;
    localparam int SC_TI = 1;
    localparam int SC_RI = 0;
    // other fields
    localparam int PWR_DBL = 7;
    localparam int TCTL_RUN = 6;
    localparam int CDIV_W = 3;
    // reset values
    localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] T1_RST = 8'h00;
    localparam logic [2:0] CDIV_RST = 3'h0;
    // rates: ticks per machine cycle, samples per bit, mode 2 tick reloads
    localparam logic [3:0] MC_LOAD = 4'hB;
    localparam logic [3:0] MC_HALF = 4'h6;
    localparam logic [3:0] SMP_MID = 4'h7;
    localparam logic [3:0] SMP_LAST = 4'hF;
    localparam logic [1:0] M2_LOAD_K1 = 2'h3;
    localparam logic [1:0] M2_LOAD_K2 = 2'h1;
    localparam logic [7:0] T1_TOP = 8'hFF;
    localparam logic [3:0] LAST_BIT8 = 4'h9;
    localparam logic [3:0] LAST_BIT9 = 4'hA;
    localparam logic [3:0] SHIFT_LAST = 4'h7;
    typedef enum logic [1:0] {
        MSP_SHIFT = 2'b00,
        MSP_UART8 = 2'b01,
        MSP_UART9F = 2'b10,
        MSP_UART9V = 2'b11
    } msp_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ASYNC = 2'b01,
        ST_SHIFT = 2'b10
    } msp_state_t;
endpackage

// file: hw/msp_div.sv
// enable-pulse divider: pulses on every (load+1)th enable
`timescale 1ns/100ps
module msp_div #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // count enable and reload
    input wire logic en,
    input wire logic [W-1:0] load,
    // divided pulse and current count
    output logic pulse,
    output logic [W-1:0] cnt
);
    logic [W-1:0] cnt_reg;

    generate
        if (W < 1) begin : g_chk
            $error("msp_div width must be at least 1");
        end
    endgenerate

    // pulse while the count is spent
    assign pulse = en && (cnt_reg == '0);
    assign cnt = cnt_reg;

    // count down, reload after the pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (en) begin
            cnt_reg <= (cnt_reg == '0) ? load : cnt_reg - 1'b1;
        end
    end
endmodule

// file: verif/msp_remote.sv
// remote serial device model: sends frames into the port and captures its frames
`timescale 1ns/100ps
module msp_remote (
    // clock
    input wire logic clk,
    // serial lines
    input wire logic txd,
    output logic rxd,
    // last captured frame
    output logic [8:0] got,
    output logic stop
);
    // line rests high, driven idle from time zero
    initial rxd = 1'b1;

    // drive one frame lsb first, stop level chosen by the caller
    task automatic send(input logic [8:0] d, input int nb, input int bl, input logic stp);
        rxd <= 1'b0;
        repeat (bl) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            rxd <= d[i];
            repeat (bl) @(posedge clk);
        end
        rxd <= stp;
        repeat (bl) @(posedge clk);
        rxd <= 1'b1;
    endtask

    // shift-mode reception: new bit on each falling shift clock, line released after the last rise
    task automatic shift_in(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd);
            rxd <= d[i];
        end
        @(posedge txd);
        rxd <= 1'b1;
    endtask

    // capture one frame at mid bit
    task automatic recv(input int nb, input int bl);
        got = 9'h000;
        @(negedge txd);
        repeat (bl + bl / 2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            got[i] = txd;
            repeat (bl) @(posedge clk);
        end
        stop = txd;
    endtask
endmodule

// file: verif/tb_msp_serial_port.sv
// testbench: register traffic, frames both ways, reset, timer run and shift mode
`timescale 1ns/100ps
module tb_msp_serial_port;
    import msp_pkg::*;
    typedef struct {
        logic [2:0] cd;
        logic dbl;
        logic [7:0] th, sc, tx;
        logic [8:0] rx;
        logic stp, ri;
    } msp_row_t;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA;
    logic RXD_OUT, RXD_OE, TXD, rm_rxd, stop;
    logic [8:0] got;
    logic [8:0] sh = 9'h000;
    logic [7:0] v;
    logic [7:0] pat [2] = '{8'h5A, 8'hA5};
    int errors = 0;
    int num_checks = 0;
    int bl, nb, n;
    // cdiv, doubler, reload, control, tx byte, rx frame, rx stop, rx done expected
    msp_row_t rows [10] = '{
        '{3'h0, 1'b1, 8'hFF, 8'h50, 8'hA5, 9'h0C3, 1'b1, 1'b1},
        '{3'h0, 1'b1, 8'hFF, 8'hD8, 8'h3C, 9'h15A, 1'b1, 1'b1},
        '{3'h0, 1'b1, 8'hFF, 8'h90, 8'h81, 9'h07E, 1'b1, 1'b1},
        '{3'h0, 1'b0, 8'hFF, 8'h98, 8'h0F, 9'h1F0, 1'b1, 1'b1},
        '{3'h0, 1'b1, 8'hFF, 8'hF0, 8'h55, 9'h055, 1'b1, 1'b0},
        '{3'h0, 1'b1, 8'hFF, 8'hF0, 8'hAA, 9'h1AA, 1'b1, 1'b1},
        '{3'h0, 1'b1, 8'hFF, 8'h70, 8'h33, 9'h0CC, 1'b0, 1'b0},
        '{3'h0, 1'b1, 8'hFF, 8'h40, 8'h77, 9'h011, 1'b1, 1'b0},
        '{3'h0, 1'b1, 8'hFF, 8'h50, 8'hE1, 9'h01E, 1'b0, 1'b1},
        '{3'h1, 1'b0, 8'hFE, 8'h50, 8'h00, 9'h0FF, 1'b1, 1'b1}};
    // shared data pin: port drives it while sending in shift mode, else the remote
    wire rxd_w = RXD_OE ? RXD_OUT : rm_rxd;

    // 200 MHz clock
    always #2.5 CLK = ~CLK;

    msp_serial_port msp_serial_port_i (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .RXD_IN(rxd_w), .RXD_OUT(RXD_OUT), .RXD_OE(RXD_OE), .TXD(TXD));
    msp_remote msp_remote_i (.clk(CLK), .txd(TXD), .rxd(rm_rxd), .got(got), .stop(stop));

    // one register write, then a gap cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask

    // one register read, data taken the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
        d = RDATA;
    endtask

    // compare and count
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // counts and verdict
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cut a hang short
    initial begin
        #400000;
        errors++;
        $display("watchdog expired");
        test_done;
    end

    // main sequence
    initial begin
        repeat (12) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        foreach (rows[i]) begin
            wr(ADR_SERIAL_CONTROL, 8'h00); // drop a frame still running from a broken stop bit
            wr(ADR_CDIV, {5'h00, rows[i].cd});
            wr(ADR_PWR, {rows[i].dbl, 7'h00});
            wr(ADR_TH1, rows[i].th);
            wr(ADR_TL1, rows[i].th);
            wr(ADR_TCTL, 8'h40);
            wr(ADR_SERIAL_CONTROL, rows[i].sc);
            nb = rows[i].sc[7] ? 9 : 8;
            bl = (rows[i].sc[7:6] == 2'b10) ? (rows[i].dbl ? 32 : 64) : (rows[i].dbl ? 1 : 2) * 192 * (256 - rows[i].th);
            bl = bl << rows[i].cd;
            fork
                wr(ADR_SERIAL_DATA_PORT, rows[i].tx);
                msp_remote_i.send(rows[i].rx, nb, bl, rows[i].stp);
                msp_remote_i.recv(nb, bl);
            join
            repeat (bl) @(posedge CLK);
            chk("tx_frame", got, nb == 9 ? {rows[i].sc[3], rows[i].tx} : {1'b0, rows[i].tx});
            chk("tx_stop", 9'(stop), 9'h001);
            rd(ADR_SERIAL_CONTROL, v);
            chk("tx_done", 9'(v[SC_TI]), 9'h001);
            chk("rx_done", 9'(v[SC_RI]), 9'(rows[i].ri));
            if (rows[i].ri) begin
                chk("rx_ninth", 9'(v[SC_RB8]), 9'(rows[i].sc[7] ? rows[i].rx[8] : rows[i].stp));
                rd(ADR_SERIAL_DATA_PORT, v);
                chk("rx_data", 9'(v), 9'(rows[i].rx[7:0]));
            end
            $display("row %0d done", i);
        end
        ARST_N <= 1'b0;
        repeat (12) @(posedge CLK);
        chk("txd_rst", 9'(TXD), 9'h001);
        ARST_N <= 1'b1;
        @(posedge CLK);
        rd(ADR_SERIAL_CONTROL, v);
        chk("serial_control_rst", 9'(v), 9'(SERIAL_CONTROL_RST));
        rd(ADR_TL1, v);
        chk("tl1_rst", 9'(v), 9'(T1_RST));
        rd(8'h80, v);
        chk("unmapped", 9'(v), 9'h000);
        foreach (pat[j]) begin
            wr(ADR_SERIAL_CONTROL, pat[j]);
            rd(ADR_SERIAL_CONTROL, v);
            chk("serial_control_rw", 9'(v), 9'(pat[j]));
        end
        $display("reset test done");
        wr(ADR_SERIAL_CONTROL, 8'h40);
        wr(ADR_PWR, 8'h80);
        wr(ADR_TH1, 8'hFF);
        wr(ADR_TL1, 8'hFF);
        wr(ADR_SERIAL_DATA_PORT, 8'h11);
        n = 0;
        repeat (400) begin
            @(posedge CLK);
            n += (TXD === 1'b0);
        end
        chk("run_off", 9'(n), 9'h000);
        wr(ADR_TCTL, 8'h40);
        n = 0;
        while (TXD !== 1'b0 && n < 400) begin
            @(posedge CLK);
            n++;
        end
        chk("run_on", 9'(TXD), 9'h000);
        repeat (2200) @(posedge CLK);
        $display("timer run test done");
        wr(ADR_SERIAL_CONTROL, 8'h00);
        wr(ADR_SERIAL_DATA_PORT, 8'h5A);
        for (int k = 0; k < 8; k++) begin
            @(negedge TXD); // data and enable stand from the falling shift clock
            @(negedge CLK);
            sh[k] = RXD_OUT;
            chk("shift_oe", 9'(RXD_OE), 9'h001);
        end
        chk("shift_data", sh, 9'h05A);
        repeat (12) @(posedge CLK);
        rd(ADR_SERIAL_CONTROL, v);
        chk("shift_done", 9'(v[SC_TI]), 9'h001);
        wr(ADR_SERIAL_CONTROL, 8'h10);
        msp_remote_i.shift_in(8'hC6);
        repeat (12) @(posedge CLK);
        rd(ADR_SERIAL_CONTROL, v);
        chk("shift_rx_done", 9'(v[SC_RI]), 9'h001);
        rd(ADR_SERIAL_DATA_PORT, v);
        chk("shift_rx_data", 9'(v), 9'h0C6);
        $display("shift test done");
        test_done;
    end
endmodule
